// ===== include/rocc_pkg.sv
// Constants for the oscillation converter control block
package rocc_pkg;

    // ------------------------------------------------------------
    // Register byte addresses
    // ------------------------------------------------------------
    localparam logic [11:0] ADDR_CTRL  = 12'h000;
    localparam logic [11:0] ADDR_TRIG  = 12'h004;
    localparam logic [11:0] ADDR_MCL   = 12'h008;
    localparam logic [11:0] ADDR_MCH   = 12'h00c;
    localparam logic [11:0] ADDR_TBL   = 12'h010;
    localparam logic [11:0] ADDR_TBH   = 12'h014;
    localparam logic [11:0] ADDR_FLAGS = 12'h018;
    localparam logic [11:0] ADDR_IRQEN = 12'h01c;

    // ------------------------------------------------------------
    // Control register fields
    // ------------------------------------------------------------
    localparam int CTL_BLOCK_EN_BIT = 0;
    localparam int CTL_MODE_LSB     = 4;
    localparam int CTL_MODE_MSB     = 5;
    localparam int CTL_EVENT_BIT    = 6;
    localparam int CTL_CONT_BIT     = 7;
    localparam int CTL_HALVE_BIT    = 8;
    localparam logic [8:0] CTL_WMASK = 9'h1f1;

    localparam logic [1:0] MODE_DC = 2'h0;
    localparam logic [1:0] MODE_AC = 2'h1;

    // ------------------------------------------------------------
    // Trigger and flag bit positions
    // ------------------------------------------------------------
    localparam int RUN_REF = 0;
    localparam int RUN_A   = 1;
    localparam int RUN_B   = 2;

    localparam int FLG_REF_DONE = 0;
    localparam int FLG_A_DONE   = 1;
    localparam int FLG_B_DONE   = 2;
    localparam int FLG_MEAS_OVF = 3;
    localparam int FLG_TB_OVF   = 4;

    // ------------------------------------------------------------
    // Reset values and counter limits
    // ------------------------------------------------------------
    localparam logic [8:0]  RST_CTRL  = 9'h000;
    localparam logic [2:0]  RST_RUN   = 3'h0;
    localparam logic [23:0] RST_CNT   = 24'h000000;
    localparam logic [4:0]  RST_FLAGS = 5'h00;
    localparam logic [23:0] CNT_MAX   = 24'hffffff;
    localparam logic [23:0] CNT_ONE   = 24'h000001;
    localparam logic [31:0] RD_ZERO   = 32'h00000000;

endpackage : rocc_pkg

// ===== verilog/rocc_sync.sv
// Two-stage synchroniser for the oscillator and event pins
`timescale 1ns/1ps
module rocc_sync
(
    input  wire logic       ref_clk_i,
    input  wire logic       nrst_i,
    input  wire logic [1:0] async_i,
    output logic      [1:0] sync_o
);

    // ------------------------------------------------------------
    // One pair of flops per pin
    // ------------------------------------------------------------
    logic [1:0] meta_r;

    genvar gi;
    generate
        for (gi = 0; gi < 2; gi++)
        begin : g_bit
            always_ff @(posedge ref_clk_i or negedge nrst_i)
            begin
                if (!nrst_i)
                begin
                    meta_r[gi] <= 1'b0;
                    sync_o[gi] <= 1'b0;
                end
                else
                begin
                    meta_r[gi] <= async_i[gi];
                    sync_o[gi] <= meta_r[gi];
                end
            end
        end
    endgenerate

endmodule : rocc_sync

// ===== verilog/rocc_ctrl.sv
// Control, counters and status of one oscillation converter channel
`timescale 1ns/1ps
module rocc_ctrl
    import rocc_pkg::*;
(
    input  wire logic        ref_clk_i,
    input  wire logic        nrst_i,
    input  wire logic        psel_i,
    input  wire logic        penable_i,
    input  wire logic        pwrite_i,
    input  wire logic [11:0] paddr_i,
    input  wire logic [31:0] pwdata_i,
    input  wire logic [3:0]  pstrb_i,
    output logic      [31:0] prdata_o,
    output logic             pready_o,
    output logic             pslverr_o,
    input  wire logic        oscillation_clock_i,
    input  wire logic        external_count_input_pin_i,
    output logic             ref_osc_en_o,
    output logic             sensor_a_osc_en_o,
    output logic             sensor_b_osc_en_o,
    output logic      [1:0]  osc_mode_select_o,
    output logic             event_count_enable_o,
    output logic             oscillation_monitor_pin_o,
    output logic             irq_o
);

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    function automatic logic [15:0] merge16
    (
        input logic [15:0] old_v,
        input logic [15:0] wd,
        input logic [1:0]  strb
    );
        logic [15:0] res;
        res = old_v;
        if (strb[0])
            res[7:0] = wd[7:0];
        if (strb[1])
            res[15:8] = wd[15:8];
        return res;
    endfunction : merge16

    function automatic logic reg_hit
    (
        input logic [11:0] a
    );
        return (a == ADDR_CTRL)  || (a == ADDR_TRIG)  ||
               (a == ADDR_MCL)   || (a == ADDR_MCH)   ||
               (a == ADDR_TBL)   || (a == ADDR_TBH)   ||
               (a == ADDR_FLAGS) || (a == ADDR_IRQEN);
    endfunction : reg_hit

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    logic [8:0]  ctrl_r;
    logic [8:0]  ctrl_nxt;
    logic [2:0]  run_r;
    logic [2:0]  run_nxt;
    logic [23:0] meas_cnt_r;
    logic [23:0] meas_cnt_nxt;
    logic [23:0] tb_cnt_r;
    logic [23:0] tb_cnt_nxt;
    logic [4:0]  flags_r;
    logic [4:0]  flags_nxt;
    logic [4:0]  irq_en_r;
    logic [4:0]  irq_en_nxt;
    logic        pready_r;
    logic        pslverr_r;
    logic [31:0] prdata_r;
    logic        src_prev_r;
    logic        osc_prev_r;
    logic        mon_r;
    logic        mon_nxt;
    logic        irq_r;

    // ------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------
    logic [1:0] pin_sync;

    rocc_sync u_sync
    (
        .ref_clk_i (ref_clk_i),
        .nrst_i    (nrst_i),
        .async_i   ({external_count_input_pin_i, oscillation_clock_i}),
        .sync_o    (pin_sync)
    );

    // ------------------------------------------------------------
    // Control field decode
    // ------------------------------------------------------------
    wire       block_en = ctrl_r[CTL_BLOCK_EN_BIT];
    wire [1:0] mode_sel = ctrl_r[CTL_MODE_MSB:CTL_MODE_LSB];
    wire       event_en = ctrl_r[CTL_EVENT_BIT];
    wire       cont_en  = ctrl_r[CTL_CONT_BIT];
    wire       halve_en = ctrl_r[CTL_HALVE_BIT];
    wire       ac_mode  = (mode_sel == MODE_AC);

    // ------------------------------------------------------------
    // Bus decode
    // ------------------------------------------------------------
    // Write lands on the edge where pready is sampled high
    wire        commit   = psel_i & penable_i & pready_r;
    wire        wr_en    = commit & pwrite_i & reg_hit(paddr_i);
    wire [15:0] wd       = pwdata_i[15:0];
    wire [1:0]  ws       = pstrb_i[1:0];
    wire        wr_ctrl  = wr_en & (paddr_i == ADDR_CTRL);
    wire        wr_trig  = wr_en & (paddr_i == ADDR_TRIG);
    wire        wr_mcl   = wr_en & (paddr_i == ADDR_MCL);
    wire        wr_mch   = wr_en & (paddr_i == ADDR_MCH);
    wire        wr_tbl   = wr_en & (paddr_i == ADDR_TBL);
    wire        wr_tbh   = wr_en & (paddr_i == ADDR_TBH);
    wire        wr_flags = wr_en & (paddr_i == ADDR_FLAGS);
    wire        wr_irqen = wr_en & (paddr_i == ADDR_IRQEN);
    wire        first_ph = psel_i & penable_i & ~pready_r;

    // ------------------------------------------------------------
    // Read mux
    // ------------------------------------------------------------
    // Reserved bits zero
    wire [31:0] rd_mux =
        (paddr_i == ADDR_CTRL)  ? {23'h000000, ctrl_r}            :
        (paddr_i == ADDR_TRIG)  ? {29'h00000000, run_r}           :
        (paddr_i == ADDR_MCL)   ? {16'h0000, meas_cnt_r[15:0]}    :
        (paddr_i == ADDR_MCH)   ? {24'h000000, meas_cnt_r[23:16]} :
        (paddr_i == ADDR_TBL)   ? {16'h0000, tb_cnt_r[15:0]}      :
        (paddr_i == ADDR_TBH)   ? {24'h000000, tb_cnt_r[23:16]}   :
        (paddr_i == ADDR_FLAGS) ? {27'h0000000, flags_r}          :
        (paddr_i == ADDR_IRQEN) ? {27'h0000000, irq_en_r}         :
                                  RD_ZERO;

    // ------------------------------------------------------------
    // Count source and edges
    // ------------------------------------------------------------
    // External or oscillator source
    wire src_lvl  = event_en ? pin_sync[1] : pin_sync[0];
    wire src_edge = src_lvl & ~src_prev_r;
    wire osc_rise = pin_sync[0] & ~osc_prev_r;

    wire ref_run  = block_en & run_r[RUN_REF];
    wire sens_run = block_en & (run_r[RUN_A] | run_r[RUN_B]);
    wire any_run  = ref_run | sens_run;

    // ------------------------------------------------------------
    // End conditions
    // ------------------------------------------------------------
    // Wrap and zero detection
    wire meas_wrap = any_run & src_edge & (meas_cnt_r == CNT_MAX);
    wire tb_ovf    = ref_run & (tb_cnt_r == CNT_MAX);
    wire tb_zero   = sens_run & (tb_cnt_r == CNT_ONE);
    wire auto_stop = (meas_wrap | tb_ovf | tb_zero) & ~cont_en;

    wire [4:0] flag_set;
    assign flag_set[FLG_REF_DONE] = meas_wrap & ref_run;
    assign flag_set[FLG_A_DONE]   = tb_zero & run_r[RUN_A];
    assign flag_set[FLG_B_DONE]   = tb_zero & run_r[RUN_B];
    assign flag_set[FLG_MEAS_OVF] = meas_wrap & sens_run;
    assign flag_set[FLG_TB_OVF]   = tb_ovf;

    // ------------------------------------------------------------
    // Trigger write value
    // ------------------------------------------------------------
    wire [2:0] trig_raw = 3'(merge16({13'h0000, run_r}, wd, ws));
    wire [2:0] trig_val;
    assign trig_val[RUN_REF] = trig_raw[RUN_REF];
    assign trig_val[RUN_A]   = trig_raw[RUN_A];
    assign trig_val[RUN_B]   = trig_raw[RUN_B] & ~ac_mode;

    // ------------------------------------------------------------
    // Next-state logic
    // ------------------------------------------------------------
    always_comb
    begin
        ctrl_nxt = ctrl_r;
        if (wr_ctrl)
            ctrl_nxt = 9'(merge16({7'h00, ctrl_r}, wd, ws)) & CTL_WMASK;
    end

    always_comb
    begin
        run_nxt = run_r;
        if (!block_en)
            run_nxt = RST_RUN;
        else if (wr_trig)
            run_nxt = trig_val;
        else if (auto_stop)
            run_nxt = RST_RUN;
    end

    always_comb
    begin
        meas_cnt_nxt = meas_cnt_r;
        if (wr_mcl)
            meas_cnt_nxt[15:0] = merge16(meas_cnt_r[15:0], wd, ws);
        else if (wr_mch)
            meas_cnt_nxt[23:16] = 8'(merge16({8'h00, meas_cnt_r[23:16]}, wd, ws));
        else if (any_run && src_edge)
            meas_cnt_nxt = meas_cnt_r + CNT_ONE;
    end

    always_comb
    begin
        // Time base counter load and count
        tb_cnt_nxt = tb_cnt_r;
        if (wr_tbl)
            tb_cnt_nxt[15:0] = merge16(tb_cnt_r[15:0], wd, ws);
        else if (wr_tbh)
            tb_cnt_nxt[23:16] = 8'(merge16({8'h00, tb_cnt_r[23:16]}, wd, ws));
        else if (ref_run)
            tb_cnt_nxt = tb_cnt_r + CNT_ONE;
        else if (sens_run)
            tb_cnt_nxt = tb_cnt_r - CNT_ONE;
    end

    always_comb
    begin
        flags_nxt = flags_r;
        if (wr_flags && ws[0])
            flags_nxt = flags_r & ~wd[4:0];
        flags_nxt = flags_nxt | flag_set;
    end

    always_comb
    begin
        irq_en_nxt = irq_en_r;
        if (wr_irqen && ws[0])
            irq_en_nxt = wd[4:0];
    end

    always_comb
    begin
        mon_nxt = 1'b0;
        if (any_run)
        begin
            if (halve_en)
                mon_nxt = osc_rise ? ~mon_r : mon_r;
            else
                mon_nxt = pin_sync[0];
        end
    end

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            ctrl_r     <= RST_CTRL;
            run_r      <= RST_RUN;
            meas_cnt_r <= RST_CNT;
            tb_cnt_r   <= RST_CNT;
            flags_r    <= RST_FLAGS;
            irq_en_r   <= RST_FLAGS;
        end
        else
        begin
            ctrl_r     <= ctrl_nxt;
            run_r      <= run_nxt;
            meas_cnt_r <= meas_cnt_nxt;
            tb_cnt_r   <= tb_cnt_nxt;
            flags_r    <= flags_nxt;
            irq_en_r   <= irq_en_nxt;
        end
    end

    always_ff @(posedge ref_clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            src_prev_r <= 1'b0;
            osc_prev_r <= 1'b0;
            mon_r      <= 1'b0;
            irq_r      <= 1'b0;
        end
        else
        begin
            src_prev_r <= src_lvl;
            osc_prev_r <= pin_sync[0];
            mon_r      <= mon_nxt;
            irq_r      <= |(flags_nxt & irq_en_nxt);
        end
    end

    // ------------------------------------------------------------
    // Bus answer
    // ------------------------------------------------------------
    // One wait state keeps read data registered
    always_ff @(posedge ref_clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            pready_r  <= 1'b0;
            pslverr_r <= 1'b0;
            prdata_r  <= RD_ZERO;
        end
        else if (first_ph)
        begin
            pready_r  <= 1'b1;
            pslverr_r <= ~reg_hit(paddr_i);
            prdata_r  <= pwrite_i ? RD_ZERO : rd_mux;
        end
        else
        begin
            pready_r  <= 1'b0;
            pslverr_r <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign prdata_o                  = prdata_r;
    assign pready_o                  = pready_r;
    assign pslverr_o                 = pslverr_r;
    assign ref_osc_en_o              = run_r[RUN_REF];
    assign sensor_a_osc_en_o         = run_r[RUN_A];
    assign sensor_b_osc_en_o         = run_r[RUN_B];
    assign osc_mode_select_o         = ctrl_r[CTL_MODE_MSB:CTL_MODE_LSB];
    assign event_count_enable_o      = ctrl_r[CTL_EVENT_BIT];
    assign oscillation_monitor_pin_o = mon_r;
    assign irq_o                     = irq_r;

endmodule : rocc_ctrl

// ===== verification/rocc_osc_model.sv
// Behavioural RC oscillator and external event source
`timescale 1ns/1ps
module rocc_osc_model
#(
    parameter real HALF_NS = 61.0
)
(
    input  wire logic run_i,
    input  wire logic evt_i,
    output logic      osc_o,
    output logic      ext_o
);
    // ----------------------------------------
    // Oscillation
    // ----------------------------------------
    // Stands still at 0 when stopped; event pin is pulled down
    initial
    begin
        osc_o = 1'b0;
        ext_o = 1'b0;
    end

    // Half period kept well above two reference clocks for the synchroniser
    always
    begin
        #(HALF_NS);
        osc_o = run_i && !evt_i && !osc_o;
        ext_o = run_i && evt_i && !ext_o;
    end
endmodule : rocc_osc_model

// ===== verification/rocc_chk.sv
// Port-level checks for the oscillation converter control block
`timescale 1ns/1ps
module rocc_chk
    import rocc_pkg::*;
(
    input wire logic        ref_clk_i,
    input wire logic        nrst_i,
    input wire logic        psel_i,
    input wire logic        penable_i,
    input wire logic        pwrite_i,
    input wire logic [11:0] paddr_i,
    input wire logic        pready_o,
    input wire logic        pslverr_o,
    input wire logic        ref_osc_en_o,
    input wire logic        sensor_a_osc_en_o,
    input wire logic        sensor_b_osc_en_o,
    input wire logic [1:0]  osc_mode_select_o,
    input wire logic        event_count_enable_o,
    input wire logic        oscillation_monitor_pin_o,
    input wire logic        irq_o
);
    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    wire [2:0] run_v = {sensor_b_osc_en_o, sensor_a_osc_en_o, ref_osc_en_o};
    wire       wr_ok = psel_i & penable_i & pwrite_i & pready_o;
    wire       hit   = (paddr_i[11:5] == 7'h00) && (paddr_i[1:0] == 2'h0);

    default clocking cb @(posedge ref_clk_i);
    endclocking
    default disable iff (!nrst_i);

    // ----------------------------------------
    // Assertions
    // ----------------------------------------
    a_rdy_wait: assert property (psel_i && penable_i && !$past(penable_i)
        |-> !pready_o ##1 pready_o) else $error("ready not after one wait");
    a_rdy_pulse: assert property (pready_o |=> !pready_o) else $error("ready too long");
    a_err_rdy: assert property (pslverr_o |-> pready_o) else $error("error without ready");
    a_err_decode: assert property (pready_o |-> pslverr_o == !hit)
        else $error("error flag does not match decode");
    a_start_wr: assert property (|(run_v & ~$past(run_v))
        |-> $past(wr_ok && paddr_i == ADDR_TRIG)) else $error("run without write");
    a_b_not_ac: assert property ($rose(sensor_b_osc_en_o)
        |-> $past(osc_mode_select_o) != MODE_AC) else $error("sensor B ran in AC");
    a_mode_wr: assert property ($changed({osc_mode_select_o, event_count_enable_o})
        |-> $past(wr_ok && paddr_i == ADDR_CTRL)) else $error("mode moved alone");
    a_irq_fall: assert property ($fell(irq_o)
        |-> $past(wr_ok) || $past(wr_ok, 2)) else $error("irq fell alone");
    a_irq_rise: assert property ($rose(irq_o) |-> $past(wr_ok) || $past(wr_ok, 2)
        || $past(|run_v) || $past(|run_v, 2)) else $error("irq rose alone");
    a_mon_idle: assert property (!(|run_v) [*3] |-> !oscillation_monitor_pin_o)
        else $error("monitor active while stopped");

    c_irq: cover property ($rose(irq_o));
    c_err: cover property (pslverr_o);
    c_stop: cover property ($fell(|run_v));
endmodule : rocc_chk

bind rocc_ctrl rocc_chk rocc_chk_i
(
    .ref_clk_i, .nrst_i, .psel_i, .penable_i, .pwrite_i, .paddr_i, .pready_o,
    .pslverr_o, .ref_osc_en_o, .sensor_a_osc_en_o, .sensor_b_osc_en_o,
    .osc_mode_select_o, .event_count_enable_o, .oscillation_monitor_pin_o, .irq_o
);

// ===== verification/rocc_ctrl_tb.sv
// Self-checking bench for the oscillation converter control block
`timescale 1ns/1ps
module rocc_ctrl_tb
    import rocc_pkg::*;
;
    logic        ref_clk_i = 1'b0;
    logic        nrst_i    = 1'b0;
    logic        psel_i    = 1'b0;
    logic        penable_i = 1'b0;
    logic        pwrite_i  = 1'b0;
    logic [11:0] paddr_i   = 12'h000;
    logic [31:0] pwdata_i  = 32'h0;
    logic [31:0] prdata_o;
    logic        pready_o, pslverr_o, irq_o;
    logic        oscillation_clock_i, external_count_input_pin_i;
    logic        ref_osc_en_o, sensor_a_osc_en_o, sensor_b_osc_en_o;
    logic [1:0]  osc_mode_select_o;
    logic        event_count_enable_o, oscillation_monitor_pin_o;
    logic [31:0] regm [8] = '{default: 32'h0};
    logic [31:0] msk  [8] = '{32'h1f1, 0, 32'hffff, 32'hff, 32'hffff, 32'hff, 0, 32'h1f};
    logic [31:0] v, q;
    logic        e;
    logic        cnt_on = 1'b0;
    int          seed, i, d, n_osc, n_mon;
    int          n_fail = 0;
    int          tests_run = 0;
    wire  [2:0]  runs = {sensor_b_osc_en_o, sensor_a_osc_en_o, ref_osc_en_o};

    always #12.5 ref_clk_i = ~ref_clk_i;
    always @(posedge oscillation_clock_i) if (cnt_on) n_osc++;
    always @(posedge oscillation_monitor_pin_o) if (cnt_on) n_mon++;

    // Byte lanes fixed: every register is a single 16-bit half
    rocc_ctrl rocc_ctrl_i
    (
        .ref_clk_i, .nrst_i, .psel_i, .penable_i, .pwrite_i, .paddr_i, .pwdata_i,
        .pstrb_i(4'h3), .prdata_o, .pready_o, .pslverr_o, .oscillation_clock_i,
        .external_count_input_pin_i, .ref_osc_en_o, .sensor_a_osc_en_o,
        .sensor_b_osc_en_o, .osc_mode_select_o, .event_count_enable_o,
        .oscillation_monitor_pin_o, .irq_o
    );

    rocc_osc_model rocc_osc_model_i
    (
        .run_i(|runs),
        .evt_i(event_count_enable_o),
        .osc_o(oscillation_clock_i),
        .ext_o(external_count_input_pin_i)
    );

    // ----------------------------------------
    // Tasks
    // ----------------------------------------
    task automatic end_sim;
        begin
            $display("comparisons %0d mismatches %0d", tests_run, n_fail);
            if (n_fail == 0 && tests_run > 0)
                $display("bench passed");
            else
                $display("bench failed");
            $finish;
        end
    endtask : end_sim

    task automatic chk(input string nm, input logic [31:0] x, input logic [31:0] g);
        begin
            tests_run++;
            if (g !== x)
            begin
                $display("MISMATCH %s expected %h seen %h", nm, x, g);
                n_fail++;
            end
        end
    endtask : chk

    // Waits on ready with a bound; answer taken at the ready edge
    task automatic apb(input logic [11:0] a, input logic w, input logic [31:0] dt,
                       output logic [31:0] rq, output logic re);
        int n;
        begin
            n = 0;
            @(posedge ref_clk_i);
            psel_i   <= 1'b1;
            pwrite_i <= w;
            paddr_i  <= a;
            pwdata_i <= dt;
            @(posedge ref_clk_i);
            penable_i <= 1'b1;
            @(posedge ref_clk_i);
            while (pready_o !== 1'b1 && n < 20)
            begin
                n++;
                @(posedge ref_clk_i);
            end
            rq = prdata_o;
            re = pslverr_o;
            if (n == 20)
            begin
                n_fail++;
                end_sim;
            end
            psel_i    <= 1'b0;
            penable_i <= 1'b0;
            @(negedge ref_clk_i);
        end
    endtask : apb

    task automatic wr(input logic [11:0] a, input logic [31:0] dt);
        logic [31:0] rq;
        logic        re;
        begin
            apb(a, 1'b1, dt, rq, re);
            regm[a[4:2]] = dt & msk[a[4:2]];
        end
    endtask : wr

    task automatic rd(input logic [11:0] a, input logic [31:0] x);
        logic [31:0] rq;
        logic        re;
        begin
            apb(a, 1'b0, 32'h0, rq, re);
            chk("prdata", x, rq);
        end
    endtask : rd

    // Flags cleared first, counters loaded low half first, one run bit only
    task automatic run(input logic [2:0] t, input logic [23:0] mc, input logic [23:0] tc,
                       input logic wt);
        int n;
        begin
            n = 0;
            wr(ADDR_FLAGS, 32'h1f);
            wr(ADDR_MCL, 32'(mc[15:0]));
            wr(ADDR_MCH, 32'(mc[23:16]));
            wr(ADDR_TBL, 32'(tc[15:0]));
            wr(ADDR_TBH, 32'(tc[23:16]));
            wr(ADDR_TRIG, 32'(t));
            chk("runs", 32'(t), 32'(runs));
            while (wt && runs !== 3'h0 && n < 3000)
            begin
                n++;
                @(posedge ref_clk_i);
            end
            if (n == 3000)
            begin
                n_fail++;
                end_sim;
            end
        end
    endtask : run

    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    initial
    begin
        seed = 78962;
        repeat (2) @(posedge ref_clk_i);
        nrst_i <= 1'b1;
        for (i = 0; i < 8; i++)
            rd(12'(i * 4), 32'h0);
        apb(12'h020, 1'b0, 32'h0, q, e);
        chk("slverr", 32'h1, 32'(e));
        chk("unmapped", 32'h0, q);
        for (i = 0; i < 8; i++)
        begin
            v = $random(seed);
            if (i != 1)
                wr(12'(i * 4), v);
            rd(12'(i * 4), regm[i]);
        end
        for (i = 0; i < 4; i++)
        begin
            wr(ADDR_CTRL, 32'(i << 4 | (i & 1) << 6));
            chk("mode", 32'(i), 32'(osc_mode_select_o));
            chk("event", 32'(i & 1), 32'(event_count_enable_o));
        end
        wr(ADDR_CTRL, 32'h0);
        wr(ADDR_TRIG, 32'h1);
        rd(ADDR_TRIG, 32'h0);
        wr(ADDR_CTRL, 32'h11);
        wr(ADDR_TRIG, 32'h4);
        rd(ADDR_TRIG, 32'h0);
        wr(ADDR_TRIG, 32'h2);
        rd(ADDR_TRIG, 32'h2);
        wr(ADDR_TRIG, 32'h0);
        rd(ADDR_TRIG, 32'h0);
        wr(ADDR_CTRL, 32'h1);
        wr(ADDR_IRQEN, 32'h1);
        run(3'h1, 24'hfffffb, 24'h0, 1'b1);
        rd(ADDR_FLAGS, 32'h01);
        chk("irq", 32'h1, 32'(irq_o));
        rd(ADDR_MCL, 32'h0);
        wr(ADDR_FLAGS, 32'h1);
        chk("irq", 32'h0, 32'(irq_o));
        rd(ADDR_FLAGS, 32'h0);
        run(3'h2, 24'h0, 24'd40, 1'b1);
        rd(ADDR_FLAGS, 32'h02);
        chk("irq", 32'h0, 32'(irq_o));
        rd(ADDR_TBL, 32'h0);
        run(3'h4, 24'hfffffe, 24'h001000, 1'b1);
        rd(ADDR_FLAGS, 32'h08);
        run(3'h4, 24'h0, 24'd20, 1'b1);
        rd(ADDR_FLAGS, 32'h04);
        run(3'h1, 24'h0, 24'hfffff0, 1'b1);
        rd(ADDR_FLAGS, 32'h10);
        wr(ADDR_CTRL, 32'h41);
        run(3'h1, 24'hfffffd, 24'h0, 1'b1);
        rd(ADDR_FLAGS, 32'h01);
        wr(ADDR_CTRL, 32'h81);
        run(3'h1, 24'hfffffe, 24'h0, 1'b0);
        for (i = 0; i < 2; i++)
        begin
            wr(ADDR_CTRL, 32'h81 | 32'(i << 8));
            n_osc = 0;
            n_mon = 0;
            cnt_on = 1'b1;
            repeat (200) @(posedge ref_clk_i);
            cnt_on = 1'b0;
            d = n_mon * (i + 1) - n_osc;
            chk("monitor", 32'h1, 32'(d >= -2 && d <= 2 && n_osc > 20));
        end
        chk("cont", 32'h1, 32'(ref_osc_en_o));
        rd(ADDR_FLAGS, 32'h01);
        wr(ADDR_CTRL, 32'h180);
        @(negedge ref_clk_i);
        chk("runs", 32'h0, 32'(runs));
        end_sim;
    end
endmodule : rocc_ctrl_tb
